/* include/pcl_regs.svh */
// Register offsets, field positions, reset values and timing counts of the supervisor
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH

`define PCL_ADDR_CTRL      3'h0
`define PCL_ADDR_LEVEL     3'h1
`define PCL_ADDR_CAUSE     3'h2
`define PCL_ADDR_IRQ_STAT  3'h3
`define PCL_ADDR_IRQ_MASK  3'h4
`define PCL_ADDR_POR_STAT  3'h5

`define PCL_CTRL_EN_BIT    7
`define PCL_CTRL_SRC_BIT   2
`define PCL_CTRL_MODE_BIT  1
`define PCL_CTRL_FLAG_BIT  0
`define PCL_CAUSE_UV_BIT   0
`define PCL_IRQ_EDGE_BIT   0
`define PCL_IRQ_RST_BIT    1
`define PCL_POR_HYST_BIT   0
`define PCL_POR_RUN_BIT    1

`define PCL_CTRL_RESET     8'h00
`define PCL_LEVEL_RESET    4'h0
`define PCL_CAUSE_RESET    1'h0
`define PCL_IRQ_RESET      2'h0

`define PCL_CLK_MHZ        200.0
`define PCL_STAB_MIN_MS    1.93
`define PCL_STAB_MAX_MS    5.39
`define PCL_STAB_MIN_CYC   ($rtoi($ceil(`PCL_STAB_MIN_MS * 1000.0 * `PCL_CLK_MHZ)))
`define PCL_STAB_MAX_CYC   ($rtoi($floor(`PCL_STAB_MAX_MS * 1000.0 * `PCL_CLK_MHZ)))

`endif

/* include/pcl_pkg.sv */
// Types shared by the supervisor modules
package pcl_pkg;
  typedef logic [7:0] pcl_byte_t;
  typedef logic [2:0] pcl_addr_t;
  typedef logic [3:0] pcl_level_t;
  typedef enum logic [1:0] {
    por_hold,
    por_wait,
    por_run
  } pcl_por_state_t;
endpackage : pcl_pkg

/* src/pcl_sync.sv */
// Two-stage synchroniser for the analog comparator outputs
module pcl_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_chk
    $error("pcl_sync: WIDTH must be at least 1");
  end

  // Stage one feeds only stage two
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      q      <= '0;
    end else if (ce) begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule : pcl_sync

/* src/pcl_top.sv */
// Power-on-clear and undervoltage detector digital supervisor
//
// Summary of operation
// - Single-threshold mode holds reset from power-up until supply exceeds the low threshold.
// - Mode 0: reset while supply below low threshold, released at or above it.
// - Mode 1: reset held at power-up until supply exceeds the high threshold.
// - Hysteretic mode: reset below low threshold, release only at the high threshold.
// - Stabilisation wait after low crossing; early high crossing stretches it to maximum.
// - Detector compares supply level or external pin, chosen by source select.
// - Reset mode: internal reset while selected input below threshold, released above.
// - Interrupt mode: event on falling below and on rising back above threshold.
// - Sixteen software-selectable supply levels passed to the analog comparator.
// - Source select is control bit 2, reset/interrupt mode is bit 1.
// - Control bit 0 reads the current comparison result while enabled.
// - An undervoltage reset sets bit 0 of the reset-cause register.
// - Interrupt output follows the flag only when enabled and in interrupt mode.
// - Enable, source and mode bits cleared by every reset except undervoltage reset.
// - Power-on-clear reset clears the whole reset-cause register.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`include "pcl_regs.svh"

module pcl_top #(
  parameter int STAB_MIN_CYC = `PCL_STAB_MIN_CYC,
  parameter int STAB_MAX_CYC = `PCL_STAB_MAX_CYC
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               ce,
  input  wire logic               por_hysteresis_select,
  input  wire logic               cmp_above_low,
  input  wire logic               cmp_above_high,
  input  wire logic               cmp_supply_below,
  input  wire logic               cmp_ext_below,
  input  wire logic               wdt_reset,
  input  wire logic               stop_mode,
  input  wire pcl_pkg::pcl_addr_t addr,
  input  wire pcl_pkg::pcl_byte_t wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output pcl_pkg::pcl_byte_t      rdata,
  output pcl_pkg::pcl_level_t     level_select,
  output logic                    detector_enable,
  output logic                    detect_source_select,
  output logic                    por_reset_n,
  output logic                    undervolt_reset,
  output logic                    sys_reset_n,
  output logic                    undervolt_irq,
  output logic                    irq
);
  import pcl_pkg::*;

  localparam int CW = $clog2(STAB_MAX_CYC + 1);

  if (STAB_MIN_CYC < 1 || STAB_MAX_CYC < STAB_MIN_CYC) begin : g_chk
    $error("pcl_top: stabilisation counts out of range");
  end

  logic [3:0]     sync_q;
  logic           low_s;
  logic           high_s;
  logic           supply_below_s;
  logic           ext_below_s;
  pcl_por_state_t state;
  pcl_por_state_t next_state;
  logic [CW-1:0]  stab_cnt;
  logic           early_high;
  logic           hyst;
  logic           strap_taken;
  logic           detect_reset_not_irq;
  logic           undervoltage_flag;
  logic           undervolt_reset_cause;
  pcl_level_t     undervolt_level_reg;
  logic [1:0]     irq_stat;
  logic [1:0]     irq_mask;

  // Detector runs on the free oscillator clock, so stop mode needs no special case
  pcl_sync #(
    .WIDTH (4)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .d      ({cmp_ext_below, cmp_supply_below, cmp_above_high, cmp_above_low}),
    .q      (sync_q)
  );

  assign low_s          = sync_q[0];
  assign high_s         = sync_q[1];
  assign supply_below_s = sync_q[2];
  assign ext_below_s    = sync_q[3];

  // Power-on-clear sequencing
  wire target_ok   = hyst ? high_s : low_s;
  wire stab_min    = stab_cnt >= CW'(STAB_MIN_CYC);
  wire stab_max    = stab_cnt >= CW'(STAB_MAX_CYC);
  wire stab_done   = early_high ? stab_max : stab_min;
  wire por_active  = (state != por_run);

  always_comb begin
    next_state = state;
    unique case (state)
      por_hold: if (low_s) next_state = por_wait;
      por_wait: begin
        if (!low_s)
          next_state = por_hold;
        else if (strap_taken && target_ok && stab_done)
          next_state = por_run;
      end
      por_run: if (!low_s) next_state = por_hold;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= por_hold;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Counter starts at the low crossing and saturates at the maximum wait
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stab_cnt   <= '0;
      early_high <= 1'b0;
    end else if (ce) begin
      if (state != por_wait) begin
        stab_cnt   <= '0;
        early_high <= 1'b0;
      end else begin
        if (!stab_max)
          stab_cnt <= stab_cnt + CW'(1);
        if (high_s && !stab_min)
          early_high <= 1'b1;
      end
    end
  end

  // Option setting is caught once after reset release, never under reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hyst        <= 1'b0;
      strap_taken <= 1'b0;
    end else if (ce && !strap_taken) begin
      hyst        <= por_hysteresis_select;
      strap_taken <= 1'b1;
    end
  end

  // Undervoltage detector
  wire sel_below  = detect_source_select ? ext_below_s : supply_below_s;
  wire next_flag  = detector_enable & sel_below;
  wire irq_mode   = detector_enable & ~detect_reset_not_irq;
  wire flag_edge  = irq_mode & (next_flag != undervoltage_flag);
  wire uv_rst_now = detector_enable & detect_reset_not_irq & undervoltage_flag;
  wire clr_ctrl   = por_active | wdt_reset;

  assign undervolt_reset = uv_rst_now;
  assign por_reset_n     = ~por_active;
  assign sys_reset_n     = ~por_active & ~uv_rst_now;
  assign undervolt_irq   = irq_mode & undervoltage_flag;
  assign irq             = |(irq_stat & irq_mask);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      undervoltage_flag <= 1'b0;
    end else if (ce) begin
      undervoltage_flag <= next_flag;
    end
  end

  // Register port decode
  wire wr_ctrl  = wr && addr == `PCL_ADDR_CTRL;
  wire wr_level = wr && addr == `PCL_ADDR_LEVEL;
  wire wr_stat  = wr && addr == `PCL_ADDR_IRQ_STAT;
  wire wr_mask  = wr && addr == `PCL_ADDR_IRQ_MASK;
  wire rd_cause = rd && addr == `PCL_ADDR_CAUSE;

  // An undervoltage reset leaves the control bits alone
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      detector_enable      <= 1'(`PCL_CTRL_RESET >> `PCL_CTRL_EN_BIT);
      detect_source_select <= 1'b0;
      detect_reset_not_irq <= 1'b0;
    end else if (ce) begin
      if (clr_ctrl) begin
        detector_enable      <= 1'b0;
        detect_source_select <= 1'b0;
        detect_reset_not_irq <= 1'b0;
      end else if (wr_ctrl) begin
        detector_enable      <= wdata[`PCL_CTRL_EN_BIT];
        detect_source_select <= wdata[`PCL_CTRL_SRC_BIT];
        detect_reset_not_irq <= wdata[`PCL_CTRL_MODE_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      undervolt_level_reg <= `PCL_LEVEL_RESET;
    end else if (ce) begin
      if (clr_ctrl)
        undervolt_level_reg <= `PCL_LEVEL_RESET;
      else if (wr_level)
        undervolt_level_reg <= wdata[3:0];
    end
  end

  assign level_select = undervolt_level_reg;

  // Set wins over the clear by read; power-on clear wins over both
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      undervolt_reset_cause <= `PCL_CAUSE_RESET;
    end else if (ce) begin
      if (por_active)
        undervolt_reset_cause <= 1'b0;
      else if (uv_rst_now)
        undervolt_reset_cause <= 1'b1;
      else if (rd_cause)
        undervolt_reset_cause <= 1'b0;
    end
  end

  // Sticky event bits, write one to clear, new events win
  wire [1:0] irq_set = {uv_rst_now, flag_edge};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= `PCL_IRQ_RESET;
      irq_mask <= `PCL_IRQ_RESET;
    end else if (ce) begin
      irq_stat <= irq_set | (irq_stat & ~(wr_stat ? wdata[1:0] : 2'h0));
      if (wr_mask)
        irq_mask <= wdata[1:0];
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  wire [7:0] ctrl_view = {detector_enable, 4'h0, detect_source_select,
                          detect_reset_not_irq, undervoltage_flag};
  wire [7:0] rd_mux =
    (addr == `PCL_ADDR_CTRL)     ? ctrl_view :
    (addr == `PCL_ADDR_LEVEL)    ? {4'h0, undervolt_level_reg} :
    (addr == `PCL_ADDR_CAUSE)    ? {7'h00, undervolt_reset_cause} :
    (addr == `PCL_ADDR_IRQ_STAT) ? {6'h00, irq_stat} :
    (addr == `PCL_ADDR_IRQ_MASK) ? {6'h00, irq_mask} :
    (addr == `PCL_ADDR_POR_STAT) ? {6'h00, ~por_active, hyst} : 8'h00;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  single_release_a: assert property ($rose(por_reset_n) && !hyst |-> $past(low_s))
    else $error("release without supply above low threshold");
  low_drop_a: assert property (ce && state == por_run && !low_s |=> !por_reset_n ##1 !por_reset_n)
    else $error("reset not asserted after supply drop");
  high_release_a: assert property ($rose(por_reset_n) && hyst |-> $past(high_s, 1))
    else $error("hysteretic release below high threshold");
  hyst_hold_a: assert property (ce && hyst && por_active && !high_s |=> !por_reset_n)
    else $error("hysteretic mode released early");
  stab_wait_a: assert property ($rose(por_reset_n) |-> $past(stab_cnt) >= CW'(STAB_MIN_CYC))
    else $error("stabilisation wait too short");
  early_stretch_a: assert property ($rose(por_reset_n) && $past(early_high) |->
    $past(stab_cnt) >= CW'(STAB_MAX_CYC))
    else $error("early high crossing not stretched");
  source_flag_a: assert property (ce && detector_enable && detect_source_select |=>
    undervoltage_flag == $past(ext_below_s))
    else $error("flag does not follow external comparison");
  uv_reset_a: assert property (ce && !clr_ctrl && detector_enable && detect_reset_not_irq
    && sel_below && !wr_ctrl |=> undervolt_reset && !sys_reset_n)
    else $error("undervoltage reset missing");
  edge_event_a: assert property (ce && irq_mode && next_flag != undervoltage_flag |=>
    irq_stat[`PCL_IRQ_EDGE_BIT])
    else $error("threshold crossing lost its interrupt event");
  flag_follow_a: assert property (ce && detector_enable |=> undervoltage_flag == $past(sel_below))
    else $error("flag does not track comparison");
  cause_set_a: assert property (ce && uv_rst_now && !por_active |=> undervolt_reset_cause)
    else $error("reset cause not recorded");
  irq_gate_a: assert property (undervolt_irq |-> detector_enable && !detect_reset_not_irq)
    else $error("interrupt outside interrupt mode");
  wdt_clear_a: assert property (ce && wdt_reset |=> !detector_enable && !detect_reset_not_irq
    && !detect_source_select)
    else $error("control not cleared by watchdog reset");
  por_cause_a: assert property (ce && por_active |=> !undervolt_reset_cause)
    else $error("reset cause survived power-on clear");

  release_c: cover property ($rose(por_reset_n));
  hyst_release_c: cover property ($rose(por_reset_n) && hyst);
  uv_reset_c: cover property ($rose(undervolt_reset));
  edge_irq_c: cover property ($rose(irq) && irq_stat[`PCL_IRQ_EDGE_BIT]);
  stop_detect_c: cover property (stop_mode && $rose(undervolt_irq));
endmodule : pcl_top

/* tb/pcl_analog_model.sv */
// Behavioural analog comparators: supply and external pin against the thresholds
module pcl_analog_model (
  input  wire logic [15:0]         supply_mv,
  input  wire logic [15:0]         ext_mv,
  input  wire pcl_pkg::pcl_level_t level_select,
  output logic                     cmp_above_low,
  output logic                     cmp_above_high,
  output logic                     cmp_supply_below,
  output logic                     cmp_ext_below
);
  timeunit 1ns;
  timeprecision 100ps;
  import pcl_pkg::*;
  // Detection levels in millivolts, index is the level select
  localparam int LVL_MV [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                                 3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
  assign cmp_above_low    = int'(supply_mv) >= 1590;
  assign cmp_above_high   = int'(supply_mv) >= 2700;
  assign cmp_supply_below = int'(supply_mv) < LVL_MV[level_select];
  assign cmp_ext_below    = int'(ext_mv) < 1210;
endmodule : pcl_analog_model

/* tb/pcl_top_tb.sv */
// Bench for the supervisor: power-on release, detector modes and register port
`include "pcl_regs.svh"
module pcl_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pcl_pkg::*;
  // Short stabilisation counts keep the run small
  localparam int MIN_C = 20;
  localparam int MAX_C = 50;
  logic        mclk, resetn, ce, hyst, wdt_reset, stop_mode, wr, rd;
  logic        above_low, above_high, supply_below, ext_below;
  logic [15:0] supply_mv, ext_mv;
  pcl_addr_t   addr;
  pcl_byte_t   wdata, rdata;
  pcl_level_t  level_select;
  logic        detector_enable, detect_source_select, por_reset_n;
  logic        undervolt_reset, sys_reset_n, undervolt_irq, irq;
  int          fails, tests_run;

  pcl_top #(.STAB_MIN_CYC(MIN_C), .STAB_MAX_CYC(MAX_C)) dut_u (
    .mclk(mclk), .resetn(resetn), .ce(ce), .por_hysteresis_select(hyst),
    .cmp_above_low(above_low), .cmp_above_high(above_high), .cmp_supply_below(supply_below),
    .cmp_ext_below(ext_below), .wdt_reset(wdt_reset), .stop_mode(stop_mode), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .level_select(level_select),
    .detector_enable(detector_enable), .detect_source_select(detect_source_select),
    .por_reset_n(por_reset_n), .undervolt_reset(undervolt_reset), .sys_reset_n(sys_reset_n),
    .undervolt_irq(undervolt_irq), .irq(irq));

  pcl_analog_model analog_u (
    .supply_mv(supply_mv), .ext_mv(ext_mv), .level_select(level_select),
    .cmp_above_low(above_low), .cmp_above_high(above_high),
    .cmp_supply_below(supply_below), .cmp_ext_below(ext_below));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr_reg(input pcl_addr_t a, input pcl_byte_t d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input pcl_addr_t a, input pcl_byte_t exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_reg

  task automatic drive(input logic [15:0] s, input logic [15:0] e);
    @(posedge mclk);
    supply_mv <= s;
    ext_mv    <= e;
  endtask : drive

  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : pause

  // Edges until power-on reset reaches the wanted level, within lo..hi
  task automatic por_wait(input logic want, input int lo, input int hi);
    int n;
    n = 0;
    while (por_reset_n !== want && n <= hi) begin
      @(posedge mclk);
      #1;
      n++;
    end
    tests_run++;
    if (n < lo || n > hi) begin
      fails++;
      $display("unexpected at %0t ns: got %h expected %h", $time, n, hi);
      if (n > hi) complete_run();
    end
  endtask : por_wait

  task automatic power_up(input logic h);
    @(posedge mclk);
    resetn    <= 1'b0;
    hyst      <= h;
    supply_mv <= 16'h0000;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
  endtask : power_up

  initial begin
    {resetn, wr, rd, wdt_reset, stop_mode, hyst} = 6'h00;
    ce = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    supply_mv = 16'h0000;
    ext_mv = 16'h05dc;
    fails = 0;
    tests_run = 0;
    power_up(1'b0);
    #1 check({6'h0, sys_reset_n, irq}, 8'h00);
    drive(16'd1800, 16'd1500);
    por_wait(1'b1, MIN_C, MIN_C + 10);
    rd_reg(`PCL_ADDR_POR_STAT, 8'h02);
    rd_reg(`PCL_ADDR_CAUSE, 8'h00);
    $display("test single-threshold power-up done");

    drive(16'd4500, 16'd1500);
    wr_reg(`PCL_ADDR_LEVEL, 8'h05);
    #1 check({4'h0, level_select}, 8'h05);
    wr_reg(`PCL_ADDR_IRQ_MASK, 8'h01);
    wr_reg(`PCL_ADDR_CTRL, 8'h80);
    // Stop mode must not halt detection
    stop_mode <= 1'b1;
    rd_reg(`PCL_ADDR_CTRL, 8'h80);
    drive(16'd3000, 16'd1500);
    pause(1);
    check({7'h0, undervolt_irq}, 8'h00);
    pause(4);
    check({6'h0, undervolt_irq, irq}, 8'h03);
    rd_reg(`PCL_ADDR_CTRL, 8'h81);
    rd_reg(`PCL_ADDR_IRQ_STAT, 8'h01);
    wr_reg(`PCL_ADDR_IRQ_STAT, 8'h01);
    #1 check({7'h0, irq}, 8'h00);
    drive(16'd4500, 16'd1500);
    pause(5);
    check({6'h0, undervolt_irq, irq}, 8'h01);
    wr_reg(`PCL_ADDR_IRQ_STAT, 8'h01);
    // Clock enable low freezes the synchroniser and the flag
    ce <= 1'b0;
    drive(16'd3000, 16'd1500);
    pause(5);
    check({6'h0, undervolt_irq, irq}, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    pause(5);
    check({6'h0, undervolt_irq, irq}, 8'h03);
    drive(16'd4500, 16'd1500);
    pause(5);
    wr_reg(`PCL_ADDR_IRQ_STAT, 8'h01);
    $display("test interrupt mode done");

    wr_reg(`PCL_ADDR_CTRL, 8'h84);
    drive(16'd4500, 16'd1000);
    pause(5);
    rd_reg(`PCL_ADDR_CTRL, 8'h85);
    check({6'h0, detector_enable, detect_source_select}, 8'h03);
    drive(16'd4500, 16'd1500);
    pause(5);
    rd_reg(`PCL_ADDR_CTRL, 8'h84);
    wr_reg(`PCL_ADDR_CTRL, 8'h86);
    drive(16'd4500, 16'd1000);
    pause(5);
    check({5'h0, undervolt_irq, undervolt_reset, sys_reset_n}, 8'h02);
    drive(16'd4500, 16'd1500);
    pause(5);
    check({6'h0, undervolt_reset, sys_reset_n}, 8'h01);
    rd_reg(`PCL_ADDR_CTRL, 8'h86);
    @(posedge mclk);
    wdt_reset <= 1'b1;
    @(posedge mclk);
    wdt_reset <= 1'b0;
    rd_reg(`PCL_ADDR_CTRL, 8'h00);
    rd_reg(`PCL_ADDR_LEVEL, 8'h00);
    rd_reg(`PCL_ADDR_CAUSE, 8'h01);
    rd_reg(3'h7, 8'h00);
    wr_reg(`PCL_ADDR_POR_STAT, 8'h00);
    rd_reg(`PCL_ADDR_POR_STAT, 8'h02);
    $display("test reset mode and other reset done");

    // Cause set again so that the power-on clear has something to clear
    wr_reg(`PCL_ADDR_CTRL, 8'h86);
    drive(16'd4500, 16'd1000);
    pause(5);
    check({7'h0, undervolt_reset}, 8'h01);

    drive(16'd1000, 16'd1500);
    por_wait(1'b0, 1, 8);
    check({7'h0, sys_reset_n}, 8'h00);
    drive(16'd1800, 16'd1500);
    por_wait(1'b1, MIN_C, MIN_C + 10);
    rd_reg(`PCL_ADDR_CAUSE, 8'h00);
    $display("test supply drop done");

    power_up(1'b1);
    drive(16'd1800, 16'd1500);
    pause(MAX_C + 20);
    check({7'h0, por_reset_n}, 8'h00);
    drive(16'd3000, 16'd1500);
    por_wait(1'b1, 0, MAX_C + 10);
    rd_reg(`PCL_ADDR_POR_STAT, 8'h03);
    drive(16'd2000, 16'd1500);
    pause(20);
    check({7'h0, por_reset_n}, 8'h01);
    drive(16'd1000, 16'd1500);
    por_wait(1'b0, 1, 8);
    drive(16'd2000, 16'd1500);
    pause(MAX_C + 20);
    check({7'h0, por_reset_n}, 8'h00);
    drive(16'd3000, 16'd1500);
    por_wait(1'b1, 0, MAX_C + 10);
    $display("test hysteretic power-up done");

    power_up(1'b0);
    drive(16'd3000, 16'd1500);
    por_wait(1'b1, MAX_C, MAX_C + 10);
    $display("test early high crossing done");
    complete_run();
  end
endmodule : pcl_top_tb
